/* src/bfq_pkg.sv */
/*
  Package for the bridge fault qualify and action block: field widths,
  mask and status bit positions, timing constants.
  Assumes a single 20 MHz core clock domain.
*/
package bfq_pkg;
  // ===========================================================
  // Widths and timing
  localparam int unsigned BFQ_NFET = 6;
  localparam int unsigned BFQ_CODE_W = 6;
  localparam int unsigned BFQ_CLK_HZ = 20_000_000;
  localparam int unsigned BFQ_QT_STEP_NS = 100;
  localparam int unsigned BFQ_TH_STEP_MV = 50;
  // Cycles per 100 ns step, at least one
  localparam int unsigned BFQ_QT_STEP_CYC_I =
    (BFQ_QT_STEP_NS * (BFQ_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned BFQ_QT_STEP_CYC = (BFQ_QT_STEP_CYC_I < 1) ? 1 : BFQ_QT_STEP_CYC_I;
  localparam int unsigned BFQ_TMR_W = 10;
  // ===========================================================
  // Register offsets
  localparam logic [3:0] BFQ_REG_CFG = 4'h0;
  localparam logic [3:0] BFQ_REG_FAULT_FLAG_OUTPUT = 4'h1;
  localparam logic [3:0] BFQ_REG_STAT = 4'h2;
  localparam logic [3:0] BFQ_REG_MASK = 4'h3;
  localparam logic [3:0] BFQ_REG_INTM = 4'h4;
  // Config fields
  localparam int unsigned BFQ_CFG_TH_LSB = 0;
  localparam int unsigned BFQ_CFG_QT_LSB = 8;
  localparam int unsigned BFQ_CFG_MODE_BIT = 16;
  localparam int unsigned BFQ_CFG_ESF_BIT = 17;
  localparam int unsigned BFQ_CFG_RDCLR_BIT = 18;
  // Status / mask bit positions for other sources
  localparam int unsigned BFQ_S_VREG = 0;
  localparam int unsigned BFQ_S_VBB = 1;
  localparam int unsigned BFQ_S_VLR = 2;
  localparam int unsigned BFQ_S_VIO = 3;
  localparam int unsigned BFQ_S_WD = 4;
  localparam int unsigned BFQ_S_ETO = 5;
  localparam int unsigned BFQ_S_OT = 6;
  localparam int unsigned BFQ_S_TW = 7;
  localparam int unsigned BFQ_S_OC = 8;
  localparam int unsigned BFQ_S_SER = 9;
  localparam int unsigned BFQ_S_MEM = 10;
  localparam int unsigned BFQ_S_VDS = 11;
  localparam int unsigned BFQ_S_BS = 12;
  localparam int unsigned BFQ_NSRC = 13;
  // Reset values
  localparam logic [31:0] BFQ_CFG_RST = 32'h0000_0A20;
  localparam logic [BFQ_NSRC-1:0] BFQ_MASK_RST = 13'h0000;
  // Every interrupt source masked until software opts in
  localparam logic [BFQ_NSRC-1:0] BFQ_INTM_RST = 13'h1FFF;
  localparam logic [BFQ_NSRC-1:0] BFQ_UNMASKABLE = 13'h0600;
endpackage

/* src/bfq_core.sv */
/*
  Fault qualification for six drain-source comparators plus fault-action
  and latching policy for the other driver faults.
  Assumes comparator and detector inputs arrive asynchronous (pins or
  analog), bridge commands and register port are on i_core_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module bfq_core
  import bfq_pkg::*;
#(
  parameter int unsigned NFET = BFQ_NFET
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Bridge commands, order AL AH BL BH CL CH
  input wire logic [NFET-1:0] i_gate_cmd,
  input wire logic [NFET-1:0] i_ds_cmp,
  input wire logic [2:0] i_bs_uv,
  input wire logic [BFQ_NSRC-1:0] i_src_fault,
  output logic [NFET-1:0] o_gate_drv,
  output logic [BFQ_CODE_W-1:0] o_ds_threshold_code,
  output logic o_fault_flag_output,
  output logic o_irq
);
  // ===========================================================
  // State
  typedef struct packed {
    logic [NFET-1:0] cmp_s1;
    logic [NFET-1:0] cmp_s2;
    logic [2:0] bs_s1;
    logic [2:0] bs_s2;
    logic [BFQ_NSRC-1:0] src_s1;
    logic [BFQ_NSRC-1:0] src_s2;
    logic [NFET-1:0] cmd_prev;
    logic [NFET*BFQ_TMR_W-1:0] deb_tmr;
    logic [BFQ_TMR_W-1:0] blank_tmr;
    logic [NFET-1:0] ds_bit;
    logic [NFET-1:0] ds_state;
    logic [2:0] bs_bit;
    logic [2:0] bs_state;
    logic [BFQ_NSRC-1:0] lat;
    logic [BFQ_NSRC-1:0] sticky;
    logic [BFQ_NSRC-1:0] mask;
    logic [BFQ_NSRC-1:0] intm;
    logic [31:0] cfg;
    logic [31:0] rdata;
  } bfq_state_t;

  bfq_state_t s_q;
  bfq_state_t s_d;

  logic [BFQ_CODE_W-1:0] qt_code;
  logic [BFQ_TMR_W-1:0] qt_cyc;
  logic mode_blank;
  logic stop_on_fault;
  logic [NFET-1:0] ds_valid;
  logic [2:0] bs_valid;
  logic [BFQ_NSRC-1:0] src_live;
  logic [NFET-1:0] kill_one;
  logic kill_all;
  logic fault_flag_output_clr;
  logic stat_clr;
  logic gen_flag;

  // Either of the two FETs of phase p set in v: two FETs per phase
  function automatic logic [2:0] phase_fets(input logic [NFET-1:0] v, input int p);
    return {2'b00, v[2*p] | v[2*p+1]};
  endfunction

  // ===========================================================
  // Config decode
  assign qt_code = s_q.cfg[BFQ_CFG_QT_LSB +: BFQ_CODE_W];
  assign qt_cyc = BFQ_TMR_W'(qt_code) * BFQ_TMR_W'(BFQ_QT_STEP_CYC);
  assign mode_blank = s_q.cfg[BFQ_CFG_MODE_BIT];
  assign stop_on_fault = s_q.cfg[BFQ_CFG_ESF_BIT];
  // Read clear only with the read-clear control at zero
  assign fault_flag_output_clr = i_rd && (i_addr == BFQ_REG_FAULT_FLAG_OUTPUT) && !s_q.cfg[BFQ_CFG_RDCLR_BIT];
  assign stat_clr = i_rd && (i_addr == BFQ_REG_STAT) && !s_q.cfg[BFQ_CFG_RDCLR_BIT];
  // Masked sources disappear entirely, except the unmaskable ones
  assign src_live = s_q.src_s2 & ~(s_q.mask & ~BFQ_UNMASKABLE);

  // ===========================================================
  // Qualification
  always_comb begin
    ds_valid = '0;
    for (int i = 0; i < NFET; i++) begin
      if (mode_blank) begin
        ds_valid[i] = s_q.cmp_s2[i] && (s_q.blank_tmr == '0);
      end else begin
        // Comparator only trusted while the FET is on
        ds_valid[i] = s_q.cmp_s2[i] && s_q.cmd_prev[i] &&
          (s_q.deb_tmr[i*BFQ_TMR_W +: BFQ_TMR_W] >= qt_cyc);
      end
    end
    if (s_q.mask[BFQ_S_VDS]) begin
      ds_valid = '0;
    end
    for (int p = 0; p < 3; p++) begin
      bs_valid[p] = s_q.bs_s2[p] && !s_q.mask[BFQ_S_BS];
    end
  end

  // ===========================================================
  // Gate action
  always_comb begin
    kill_one = s_q.ds_state;
    for (int p = 0; p < 3; p++) begin
      if (s_q.bs_state[p]) begin
        kill_one[2*p] = 1'b1;
        kill_one[2*p+1] = 1'b1;
      end
    end
    kill_all = src_live[BFQ_S_VREG] || src_live[BFQ_S_VIO] || src_live[BFQ_S_WD] ||
      src_live[BFQ_S_MEM] || s_q.lat[BFQ_S_VIO] || s_q.lat[BFQ_S_WD] ||
      s_q.lat[BFQ_S_MEM];
    if (stop_on_fault) begin
      kill_all = kill_all || src_live[BFQ_S_VBB] || src_live[BFQ_S_VLR] ||
        s_q.lat[BFQ_S_VLR] || src_live[BFQ_S_ETO] || src_live[BFQ_S_OT] ||
        s_q.lat[BFQ_S_OT];
      kill_all = kill_all || (|s_q.ds_state) || (|s_q.bs_state);
    end
    gen_flag = (|s_q.ds_state) || (|s_q.bs_state) || (|s_q.lat) ||
      (|(src_live & ~(13'h1 << BFQ_S_SER)));
  end

  // Bridge output, held off during reset by the reset itself
  assign o_gate_drv = (kill_all || i_rst) ? '0 : (i_gate_cmd & ~kill_one);
  assign o_fault_flag_output = gen_flag;
  assign o_ds_threshold_code = s_q.cfg[BFQ_CFG_TH_LSB +: BFQ_CODE_W];
  assign o_rdata = s_q.rdata;
  assign o_irq = |(s_q.sticky & ~s_q.intm);

  // ===========================================================
  // Next state
  always_comb begin
    logic [NFET-1:0] rise;
    logic [BFQ_NSRC-1:0] ev;
    rise = '0;
    ev = '0;
    s_d = s_q;
    s_d.cmp_s1 = i_ds_cmp;
    s_d.cmp_s2 = s_q.cmp_s1;
    s_d.bs_s1 = i_bs_uv;
    s_d.bs_s2 = s_q.bs_s1;
    s_d.src_s1 = i_src_fault;
    s_d.src_s2 = s_q.src_s1;
    s_d.cmd_prev = i_gate_cmd;
    rise = i_gate_cmd & ~s_q.cmd_prev;

    // Independent debounce timers, saturating at the qualify time
    for (int i = 0; i < NFET; i++) begin
      if (!(s_q.cmp_s2[i] && s_q.cmd_prev[i]) || mode_blank) begin
        s_d.deb_tmr[i*BFQ_TMR_W +: BFQ_TMR_W] = '0;
      end else if (s_q.deb_tmr[i*BFQ_TMR_W +: BFQ_TMR_W] < qt_cyc) begin
        s_d.deb_tmr[i*BFQ_TMR_W +: BFQ_TMR_W] = s_q.deb_tmr[i*BFQ_TMR_W +: BFQ_TMR_W] + 1'b1;
      end
    end

    // Shared blanking timer, retriggered by any gate command edge
    if (i_gate_cmd != s_q.cmd_prev) begin
      s_d.blank_tmr = qt_cyc;
    end else if (s_q.blank_tmr != '0) begin
      s_d.blank_tmr = s_q.blank_tmr - 1'b1;
    end

    // Drain-source fault state: recommand-on clears it only without stop
    if (!stop_on_fault) begin
      s_d.ds_state = s_q.ds_state & ~rise;
      for (int p = 0; p < 3; p++) begin
        if (phase_fets(rise, p) != 3'b000) begin
          s_d.bs_state[p] = 1'b0;
        end
      end
    end
    if (fault_flag_output_clr) begin
      s_d.ds_bit = '0;
      s_d.ds_state = '0;
      s_d.bs_bit = '0;
      s_d.bs_state = '0;
    end
    // Set wins over every clear
    s_d.ds_bit = s_d.ds_bit | ds_valid;
    s_d.ds_state = s_d.ds_state | ds_valid;
    s_d.bs_bit = s_d.bs_bit | bs_valid;
    s_d.bs_state = s_d.bs_state | bs_valid;

    // Latched fault states for other sources
    if (stat_clr) begin
      s_d.lat = '0;
    end
    s_d.lat[BFQ_S_VLR] = s_d.lat[BFQ_S_VLR] | src_live[BFQ_S_VLR];
    s_d.lat[BFQ_S_VIO] = s_d.lat[BFQ_S_VIO] | src_live[BFQ_S_VIO];
    s_d.lat[BFQ_S_WD] = s_d.lat[BFQ_S_WD] | src_live[BFQ_S_WD];
    s_d.lat[BFQ_S_MEM] = s_d.lat[BFQ_S_MEM] | src_live[BFQ_S_MEM];
    s_d.lat[BFQ_S_OT] = s_d.lat[BFQ_S_OT] | (src_live[BFQ_S_OT] & stop_on_fault);

    // Status bits, sticky, cleared by reading status
    ev = src_live;
    ev[BFQ_S_VDS] = |ds_valid;
    ev[BFQ_S_BS] = |bs_valid;
    if (stat_clr) begin
      s_d.sticky = '0;
    end
    s_d.sticky = s_d.sticky | ev;

    // Register writes
    if (i_wr) begin
      unique case (i_addr)
        BFQ_REG_CFG: s_d.cfg = i_wdata;
        BFQ_REG_MASK: s_d.mask = i_wdata[BFQ_NSRC-1:0];
        BFQ_REG_INTM: s_d.intm = i_wdata[BFQ_NSRC-1:0];
        default: s_d.cfg = s_d.cfg;
      endcase
    end

    // Read data, one cycle after the strobe
    s_d.rdata = '0;
    if (i_rd) begin
      unique case (i_addr)
        BFQ_REG_CFG: s_d.rdata = s_q.cfg & 32'h0007_3F3F;
        BFQ_REG_FAULT_FLAG_OUTPUT: s_d.rdata = {20'h0_0000, 1'b0, s_q.bs_bit, 2'b00, s_q.ds_bit};
        BFQ_REG_STAT: s_d.rdata = {19'h0_0000, s_q.sticky};
        BFQ_REG_MASK: s_d.rdata = {19'h0_0000, s_q.mask};
        BFQ_REG_INTM: s_d.rdata = {19'h0_0000, s_q.intm};
        default: s_d.rdata = '0;
      endcase
    end
  end

  // ===========================================================
  // Registers
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '0;
      s_q.cfg <= BFQ_CFG_RST;
      s_q.mask <= BFQ_MASK_RST;
      s_q.intm <= BFQ_INTM_RST;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

/* dv/bfq_mcu.sv */
/* Controller model: drives the bridge commands and sheds a cut FET.
   Assumes the block's gate outputs follow its command inputs. */
`timescale 1ns/100ps
`default_nettype none
module bfq_mcu
  import bfq_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [BFQ_NFET-1:0] i_want,
  input wire logic i_shed,
  input wire logic [BFQ_NFET-1:0] i_gate_drv,
  output logic [BFQ_NFET-1:0] o_gate_cmd
);
  // ===========================================================
  // Shedding
  logic [BFQ_NFET-1:0] off_q;
  // Cut FET held off one cycle, so its command rises again
  assign o_gate_cmd = i_want & ~off_q;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      off_q <= '0;
    end else begin
      off_q <= i_shed ? (o_gate_cmd & ~i_gate_drv) : '0;
    end
  end
endmodule
`default_nettype wire

/* dv/bfq_monitor.sv */
/* Port checker for bfq_core, bound below.
   Assumes one core clock and the async high reset. */
`timescale 1ns/100ps
`default_nettype none
module bfq_monitor
  import bfq_pkg::*;
#(
  parameter int unsigned NFET = BFQ_NFET
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic [NFET-1:0] i_gate_cmd,
  input wire logic [BFQ_NSRC-1:0] i_src_fault,
  input wire logic [NFET-1:0] o_gate_drv,
  input wire logic [BFQ_CODE_W-1:0] o_ds_threshold_code,
  input wire logic o_fault_flag_output
);
  // ===========================================================
  // Relations; sync stages allow for 5 cycles on live sources
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  property p_gate_sub; (o_gate_drv & ~i_gate_cmd) == '0; endproperty
  a_gate_sub: assert property (p_gate_sub) else $error("gate without command");
  property p_calm; !o_fault_flag_output |-> o_gate_drv == i_gate_cmd; endproperty
  a_calm: assert property (p_calm) else $error("gate cut without flag");
  property p_crit; i_src_fault[BFQ_S_VREG] [*5] |-> o_gate_drv == '0 && o_fault_flag_output; endproperty
  a_crit: assert property (p_crit) else $error("regulator fault kept gates");
  property p_mem; i_src_fault[BFQ_S_MEM] [*5] |-> o_gate_drv == '0 && o_fault_flag_output; endproperty
  a_mem: assert property (p_mem) else $error("memory fault kept gates");
  property p_rd_idle; !$past(i_rd) |-> o_rdata == '0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
  property p_thr_wr; i_wr && i_addr == BFQ_REG_CFG |=> o_ds_threshold_code == $past(i_wdata[5:0]); endproperty
  a_thr_wr: assert property (p_thr_wr) else $error("threshold not written");
  property p_thr_hold; !$past(i_rst) && !(i_wr && i_addr == BFQ_REG_CFG) |=> $stable(o_ds_threshold_code); endproperty
  a_thr_hold: assert property (p_thr_hold) else $error("threshold moved");
  property p_thr_rst; $fell(i_rst) && !i_wr |=> o_ds_threshold_code == BFQ_CFG_RST[5:0]; endproperty
  a_thr_rst: assert property (p_thr_rst) else $error("threshold reset value");
endmodule
bind bfq_core bfq_monitor #(.NFET(NFET)) u_mon (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_gate_cmd(i_gate_cmd),
  .i_src_fault(i_src_fault), .o_gate_drv(o_gate_drv), .o_ds_threshold_code(o_ds_threshold_code),
  .o_fault_flag_output(o_fault_flag_output));
`default_nettype wire

/* dv/tb.sv */
/* Bench for bfq_core: register tasks, fault scenarios, verdict.
   Assumes bfq_mcu drives the bridge commands. */
`timescale 1ns/100ps
`default_nettype none
module tb;
  import bfq_pkg::*;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, shed = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [5:0] want = 6'h00, cmp = 6'h00, cmd, drv, thr;
  logic [12:0] src = 13'h0000;
  logic [2:0] bs = 3'h0;
  logic flag, irq;
  int n_mismatch = 0, n_tests = 0;
  bfq_mcu mcu (.i_core_clk(clk), .i_rst(rst), .i_want(want), .i_shed(shed), .i_gate_drv(drv), .o_gate_cmd(cmd));
  bfq_core dut (.i_core_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_gate_cmd(cmd), .i_ds_cmp(cmp), .i_bs_uv(bs), .i_src_fault(src), .o_gate_drv(drv),
    .o_ds_threshold_code(thr), .o_fault_flag_output(flag), .o_irq(irq));
  // ===========================================================
  // Clock and tasks; cyc, wr_reg and rd_reg start and end on a rising edge
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  // Data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", exp, rdata);
    @(posedge clk);
  endtask
  // Bounded wait; a timeout ends the run
  task automatic wait_flag(input logic v);
    int i;
    #1;
    for (i = 0; i < 200; i++) begin
      if (flag === v) break;
      @(posedge clk);
      #1;
    end
    chk("flag", 32'(v), 32'(flag));
    if (flag !== v) close_out();
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ===========================================================
  // Scenarios; qualify code 2 gives 4 cycles
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd_reg(BFQ_REG_CFG, BFQ_CFG_RST);
    rd_reg(4'hF, 32'h0);
    wr_reg(BFQ_REG_CFG, 32'h0000_023F);
    want <= 6'h3F;
    shed <= 1'b1;
    cyc(3);
    #1 chk("thr", 32'h3F, 32'(thr));
    for (int k = 0; k < 6; k++) begin
      cyc(1);
      cmp <= 6'h01 << k;
      cyc(3);
      cmp <= 6'h00;
      cyc(8);
      #1 chk("glitch", 32'h0, 32'(flag));
      cyc(1);
      cmp <= 6'h01 << k;
      wait_flag(1'b1);
      cyc(1);
      #1 chk("one cut", 32'h3F & ~(32'h1 << k), 32'(drv));
      cyc(1);
      cmp <= 6'h00;
      wait_flag(1'b0);
    end
    cyc(1);
    rd_reg(BFQ_REG_FAULT_FLAG_OUTPUT, 32'h3F);
    rd_reg(BFQ_REG_FAULT_FLAG_OUTPUT, 32'h0);
    // Comparator ignored on idle FETs
    want <= 6'h00;
    cmp <= 6'h3F;
    cyc(12);
    #1 chk("idle", 32'h0, 32'(flag));
    cyc(1);
    cmp <= 6'h00;
    want <= 6'h3F;
    shed <= 1'b0;
    wr_reg(BFQ_REG_CFG, 32'h0002_023F);
    cmp <= 6'h04;
    cyc(10);
    cmp <= 6'h00;
    want <= 6'h3B;
    cyc(3);
    want <= 6'h3F;
    cyc(3);
    #1 chk("all cut", 32'h40, 32'({flag, drv}));
    cyc(1);
    rd_reg(BFQ_REG_FAULT_FLAG_OUTPUT, 32'h04);
    cyc(2);
    #1 chk("released", 32'h3F, 32'({flag, drv}));
    // Blanking, 8 cycles, restarted every 3 cycles
    cyc(1);
    wr_reg(BFQ_REG_CFG, 32'h0001_043F);
    cmp <= 6'h02;
    repeat (6) begin
      want <= 6'h3E;
      cyc(3);
      want <= 6'h3F;
      cyc(3);
    end
    #1 chk("blanked", 32'h3F, 32'({flag, drv}));
    wait_flag(1'b1);
    cyc(1);
    cmp <= 6'h00;
    want <= 6'h3D;
    cyc(2);
    want <= 6'h3F;
    wait_flag(1'b0);
    cyc(1);
    rd_reg(BFQ_REG_STAT, 32'h0800);
    wr_reg(BFQ_REG_INTM, 32'h0);
    src <= 13'h0080;
    cyc(5);
    #1 chk("warn", 32'h7F, 32'({irq, drv}));
    cyc(1);
    src <= 13'h0000;
    cyc(3);
    rd_reg(BFQ_REG_STAT, 32'h0080);
    #1 chk("irq", 32'h0, 32'(irq));
    cyc(1);
    wr_reg(BFQ_REG_MASK, 32'h0080);
    src <= 13'h0080;
    cyc(5);
    #1 chk("masked", 32'h0, 32'({irq, flag}));
    cyc(1);
    src <= 13'h0001;
    cyc(6);
    #1 chk("crit", 32'h0, 32'(drv));
    cyc(1);
    src <= 13'h0400;
    cyc(6);
    src <= 13'h0000;
    cyc(4);
    #1 chk("mem", 32'h0, 32'(drv));
    cyc(1);
    rd_reg(BFQ_REG_STAT, 32'h0401);
    cyc(2);
    #1 chk("cleared", 32'h3F, 32'(drv));
    // Bootstrap fault on phase A: both FETs of the phase cut, latched
    cyc(1);
    bs <= 3'h1;
    cyc(4);
    #1 chk("boot", 32'h7C, 32'({flag, drv}));
    cyc(1);
    bs <= 3'h0;
    want <= 6'h3E;
    cyc(4);
    want <= 6'h3F;
    cyc(3);
    #1 chk("boot off", 32'h3F, 32'({flag, drv}));
    cyc(1);
    rd_reg(BFQ_REG_FAULT_FLAG_OUTPUT, 32'h0102);
    close_out();
  end
endmodule
`default_nettype wire
